// File: logic/hvpd_pin_classify.sv
`timescale 1ns/1ps
module hvpd_pin_classify
  import hvpd_pkg::*;
(
  // monitored pin
  input wire logic drv_on,
  input wire logic [CUR_W-1:0] current,
  // selected conditions
  input wire logic [FIELD_W-1:0] sc_sel,
  input wire logic [FIELD_W-1:0] ol_sel,
  // result
  output hvpd_cond_type cond
);

  // off beats short, short beats open load
  always_comb begin
    if (!drv_on) begin
      cond = COND_OFF;
    end else if (current > SC_LIMIT[sc_sel]) begin
      cond = COND_SHORT;
    end else if (current < OL_LIMIT[ol_sel]) begin
      cond = COND_OPEN;
    end else begin
      cond = COND_OK;
    end
  end

endmodule

// File: logic/hvpd_pkg.sv
package hvpd_pkg;

  // pin and field geometry
  localparam int NUM_PINS = 8;
  localparam int PINS_PER_BANK = 4;
  localparam int FIELD_W = 2;
  localparam int CUR_W = 8;
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_B0_COND = 8'h36;
  localparam logic [7:0] IDX_B0_SC = 8'h39;
  localparam logic [7:0] IDX_B0_OL = 8'h3a;
  localparam logic [7:0] IDX_B1_COND = 8'h46;
  localparam logic [7:0] IDX_B1_SC = 8'h49;
  localparam logic [7:0] IDX_B1_OL = 8'h4a;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h60;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h61;

  // values after reset
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h00;
  localparam logic [15:0] RST_COND = 16'h0000;

  // two-bit driver condition codes
  typedef enum logic [1:0] {
    COND_OK = 2'h0,
    COND_OPEN = 2'h1,
    COND_SHORT = 2'h2,
    COND_OFF = 2'h3
  } hvpd_cond_type;

  // current codes for the four short-circuit conditions, above is a short
  localparam logic [7:0] SC_LIMIT [4] = '{8'hc0, 8'hd0, 8'he0, 8'hf0};
  // current codes for the four open-load conditions, below is an open load
  localparam logic [7:0] OL_LIMIT [4] = '{8'h04, 8'h08, 8'h10, 8'h20};

endpackage

// File: logic/hvpd_top.sv
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
// Overview of operation
// - each pin reports 00 ok, 01 open load, 10 short, 11 driver off.
// - read-only byte at 46h holds pins 8..5 status, pin 8 in 7:6.
// - each pin has a read/write 2-bit short-circuit condition select.
// - byte 39h holds short selects of pins 4..1, pin 4 in 7:6.
// - byte 49h holds short selects of pins 8..5, pin 8 in 7:6.
// - byte 3Ah holds read/write open-load selects of pins 4..1.
// - byte 4Ah holds open-load selects, pin 8 in bits 7:6.
module hvpd_top
  import hvpd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // pin monitoring
  input wire logic [NUM_PINS-1:0] hv_pin_drv_on,
  input wire logic [NUM_PINS*CUR_W-1:0] hv_pin_current,
  // interrupt
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic ack_r;
  logic [DAT_W-1:0] dat_r;
  logic irq_r;
  logic [7:0] b0_sc_r;
  logic [7:0] b0_ol_r;
  logic [7:0] b1_sc_r;
  logic [7:0] b1_ol_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_mask_r;
  logic [7:0] irq_stat_nxt;
  logic [15:0] cond_r;
  logic [15:0] cond_nxt;
  logic [15:0] sc_flat;
  logic [15:0] ol_flat;
  logic [7:0] cond_event;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [7:0] rd_byte;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // word index from the byte address
  function automatic logic [7:0] reg_index(input logic [ADR_W-1:0] adr);
    reg_index = adr[9:2];
  endfunction

  // low byte of a write lands on a given register
  function automatic logic hit_write(input logic go, input logic [ADR_W-1:0] adr,
                                     input logic [7:0] idx);
    hit_write = go && (reg_index(adr) == idx);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // wishbone handshake

  // new request only while no ack is standing
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_go = req && wb_we_i && wb_sel_i[0];
  assign rd_go = req && !wb_we_i;

  // ack for one cycle per request
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  assign wb_ack_o = ack_r;

  //////////////////////////////////////////////////////////////////////////////
  // threshold selection registers

  // bank 0 short-circuit selects
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      b0_sc_r <= RST_SEL;
    end else if (hit_write(wr_go, wb_adr_i, IDX_B0_SC)) begin
      b0_sc_r <= wb_dat_i[7:0];
    end
  end

  // bank 0 open-load selects
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      b0_ol_r <= RST_SEL;
    end else if (hit_write(wr_go, wb_adr_i, IDX_B0_OL)) begin
      b0_ol_r <= wb_dat_i[7:0];
    end
  end

  // bank 1 short-circuit selects
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      b1_sc_r <= RST_SEL;
    end else if (hit_write(wr_go, wb_adr_i, IDX_B1_SC)) begin
      b1_sc_r <= wb_dat_i[7:0];
    end
  end

  // bank 1 open-load selects
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      b1_ol_r <= RST_SEL;
    end else if (hit_write(wr_go, wb_adr_i, IDX_B1_OL)) begin
      b1_ol_r <= wb_dat_i[7:0];
    end
  end

  // pin n field sits at bits 2n-1:2n-2 of the flat vectors
  assign sc_flat = {b1_sc_r, b0_sc_r};
  assign ol_flat = {b1_ol_r, b0_ol_r};

  //////////////////////////////////////////////////////////////////////////////
  // per-pin condition classification

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      hvpd_cond_type cond_w;

      // compare current against the pin's own selections
      hvpd_pin_classify u_classify (
        .drv_on(hv_pin_drv_on[gi]),
        .current(hv_pin_current[gi*CUR_W +: CUR_W]),
        .sc_sel(sc_flat[gi*FIELD_W +: FIELD_W]),
        .ol_sel(ol_flat[gi*FIELD_W +: FIELD_W]),
        .cond(cond_w)
      );

      assign cond_nxt[gi*FIELD_W +: FIELD_W] = cond_w;
      // a change of code is an event
      assign cond_event[gi] = (cond_w != cond_r[gi*FIELD_W +: FIELD_W]);
    end
  endgenerate

  // status codes, refreshed every cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cond_r <= RST_COND;
    end else begin
      cond_r <= cond_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  // set wins over a write-one clear in the same cycle
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (hit_write(wr_go, wb_adr_i, IDX_IRQ_STAT)) begin
      irq_stat_nxt = irq_stat_r & ~wb_dat_i[7:0];
    end
    irq_stat_nxt = irq_stat_nxt | cond_event;
  end

  // sticky per-pin change flags
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_r <= RST_STAT;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // interrupt mask, one bit per pin
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_r <= RST_MASK;
    end else if (hit_write(wr_go, wb_adr_i, IDX_IRQ_MASK)) begin
      irq_mask_r <= wb_dat_i[7:0];
    end
  end

  // level interrupt while any unmasked flag stands
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign irq = irq_r;

  //////////////////////////////////////////////////////////////////////////////
  // read path

  // byte selection, unmapped reads as zero
  always_comb begin
    unique case (reg_index(wb_adr_i))
      IDX_B0_COND: rd_byte = cond_r[7:0];
      IDX_B1_COND: rd_byte = cond_r[15:8];
      IDX_B0_SC: rd_byte = b0_sc_r;
      IDX_B0_OL: rd_byte = b0_ol_r;
      IDX_B1_SC: rd_byte = b1_sc_r;
      IDX_B1_OL: rd_byte = b1_ol_r;
      IDX_IRQ_STAT: rd_byte = irq_stat_r;
      IDX_IRQ_MASK: rd_byte = irq_mask_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // read data captured with the request, held until the next read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dat_r <= 32'h0000_0000;
    end else if (rd_go) begin
      dat_r <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_dat_o = dat_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  // ack is a single-cycle pulse
  property p_ack_pulse;
    @(posedge mclk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held for more than one cycle");

  // a driver switched off reports code 11
  property p_off_code;
    @(posedge mclk) disable iff (!resetn)
      !hv_pin_drv_on[7] |=> cond_r[15:14] == 2'h3;
  endproperty
  a_off_code: assert property (p_off_code)
    else $error("pin 8 off but code is not 11");

  // bank 1 status read returns pins 8..5 with upper bits zero
  property p_b1_status_read;
    logic [7:0] snap;
    @(posedge mclk) disable iff (!resetn)
      (rd_go && reg_index(wb_adr_i) == IDX_B1_COND, snap = cond_r[15:8])
        |=> wb_ack_o && wb_dat_o == {24'h00_0000, snap};
  endproperty
  a_b1_status_read: assert property (p_b1_status_read)
    else $error("bank 1 status read data wrong");

  // pin 1 short select takes the written low field
  property p_sc_pin1_write;
    @(posedge mclk) disable iff (!resetn)
      hit_write(wr_go, wb_adr_i, IDX_B0_SC)
        |=> sc_flat[1:0] == $past(wb_dat_i[1:0]);
  endproperty
  a_sc_pin1_write: assert property (p_sc_pin1_write)
    else $error("pin 1 short select not updated");

  // bank 0 short selects read back with pin 4 on top
  property p_b0_sc_read;
    @(posedge mclk) disable iff (!resetn)
      (rd_go && reg_index(wb_adr_i) == IDX_B0_SC)
        |=> wb_dat_o[7:6] == $past(b0_sc_r[7:6]) && wb_dat_o[31:8] == 24'h00_0000;
  endproperty
  a_b0_sc_read: assert property (p_b0_sc_read)
    else $error("bank 0 short select read wrong");

  // bank 1 short write reaches pin 8 field
  property p_b1_sc_write;
    @(posedge mclk) disable iff (!resetn)
      hit_write(wr_go, wb_adr_i, IDX_B1_SC) |=> sc_flat[15:14] == $past(wb_dat_i[7:6]);
  endproperty
  a_b1_sc_write: assert property (p_b1_sc_write)
    else $error("pin 8 short select not updated");

  // bank 0 open-load write reaches pin 4 field
  property p_b0_ol_write;
    @(posedge mclk) disable iff (!resetn)
      hit_write(wr_go, wb_adr_i, IDX_B0_OL) |=> ol_flat[7:6] == $past(wb_dat_i[7:6]);
  endproperty
  a_b0_ol_write: assert property (p_b0_ol_write)
    else $error("pin 4 open-load select not updated");

  // bank 1 open-load select read returns the pin 8 field in bits 7:6
  property p_b1_ol_read;
    @(posedge mclk) disable iff (!resetn)
      (rd_go && reg_index(wb_adr_i) == IDX_B1_OL)
        |=> wb_dat_o[7:6] == $past(ol_flat[15:14]);
  endproperty
  a_b1_ol_read: assert property (p_b1_ol_read)
    else $error("pin 8 open-load select read wrong");

  // current above the selected short limit gives code 10
  property p_short_detect;
    @(posedge mclk) disable iff (!resetn)
      (hv_pin_drv_on[0] && hv_pin_current[7:0] > SC_LIMIT[sc_flat[1:0]])
        |=> cond_r[1:0] == 2'h2;
  endproperty
  a_short_detect: assert property (p_short_detect)
    else $error("pin 1 short not reported");

  // current below the selected open limit gives code 01
  property p_open_detect;
    @(posedge mclk) disable iff (!resetn)
      (hv_pin_drv_on[0] && hv_pin_current[7:0] <= SC_LIMIT[sc_flat[1:0]]
        && hv_pin_current[7:0] < OL_LIMIT[ol_flat[1:0]])
        |=> cond_r[1:0] == 2'h1;
  endproperty
  a_open_detect: assert property (p_open_detect)
    else $error("pin 1 open load not reported");

  // a code change raises its sticky flag and then the interrupt
  property p_event_irq;
    @(posedge mclk) disable iff (!resetn)
      (cond_event[0] && irq_mask_r[0]) ##1 irq_mask_r[0] |=> irq;
  endproperty
  a_event_irq: assert property (p_event_irq)
    else $error("unmasked event did not raise interrupt");

  // a write without the low byte lane leaves the bank 0 short and bank 1 open-load selects alone
  property p_sel_ignored;
    @(posedge mclk) disable iff (!resetn)
      (req && wb_we_i && !wb_sel_i[0]) |=> $stable(b0_sc_r) && $stable(b1_ol_r);
  endproperty
  a_sel_ignored: assert property (p_sel_ignored)
    else $error("write without low byte lane changed a select");

  // a code change sets its flag even against a same-cycle clear
  property p_event_sets_flag;
    @(posedge mclk) disable iff (!resetn)
      cond_event[0] |=> irq_stat_r[0];
  endproperty
  a_event_sets_flag: assert property (p_event_sets_flag)
    else $error("pin 1 code change did not set its flag");

endmodule

// File: verification/hvpd_load_model.sv
`timescale 1ns/1ps
module hvpd_load_model
  import hvpd_pkg::*;
(
  // clock
  input wire logic mclk,
  // load commands from the bench
  input wire logic [NUM_PINS-1:0] load_on,
  input wire logic [NUM_PINS*CUR_W-1:0] load_cur,
  // monitored pin lines
  output logic [NUM_PINS-1:0] hv_pin_drv_on,
  output logic [NUM_PINS*CUR_W-1:0] hv_pin_current
);
  // loads start switched off with no current
  initial begin
    hv_pin_drv_on = '0;
    hv_pin_current = '0;
  end

  // load current settles one cycle after a command, none flows when off
  always @(posedge mclk) begin
    hv_pin_drv_on <= load_on;
    for (int i = 0; i < NUM_PINS; i++) begin
      hv_pin_current[i*CUR_W +: CUR_W] <= load_on[i] ? load_cur[i*CUR_W +: CUR_W] : 8'h00;
    end
  end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench
  import hvpd_pkg::*;
;
  typedef struct packed {logic we; logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} hvpd_row_type;
  logic mclk;
  logic resetn;
  logic cyc;
  logic stb;
  logic we;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [DAT_W-1:0] wdat;
  logic [DAT_W-1:0] rdat;
  logic ack;
  logic irq;
  logic [NUM_PINS-1:0] drv_on;
  logic [NUM_PINS*CUR_W-1:0] cur;
  logic [NUM_PINS-1:0] load_on;
  logic [NUM_PINS*CUR_W-1:0] load_cur;
  logic [7:0] r;
  logic [23:0] rhi;
  logic [3:0] wsel = 4'hf;
  logic [7:0] sc;
  logic [7:0] ol;
  int error_cnt = 0;
  int compares = 0;
  hvpd_row_type rows [11] = '{
    '{1'b1, 8'h39, 8'ha5, 8'h00},
    '{1'b1, 8'h3a, 8'h5a, 8'h00},
    '{1'b1, 8'h49, 8'hc3, 8'h00},
    '{1'b1, 8'h4a, 8'h3c, 8'h00},
    '{1'b0, 8'h39, 8'h00, 8'ha5},
    '{1'b0, 8'h3a, 8'h00, 8'h5a},
    '{1'b0, 8'h49, 8'h00, 8'hc3},
    '{1'b0, 8'h4a, 8'h00, 8'h3c},
    '{1'b1, 8'h46, 8'h00, 8'h00},
    '{1'b0, 8'h46, 8'h00, 8'hff},
    '{1'b0, 8'h10, 8'h00, 8'h00}
  };
  logic [7:0] sel_idx [4] = '{8'h39, 8'h3a, 8'h49, 8'h4a};

  ////////////////////////////////////////////////////////////////////////////
  // design and loads
  hvpd_top u_dut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .hv_pin_drv_on(drv_on), .hv_pin_current(cur), .irq(irq));
  hvpd_load_model u_loads (.mclk(mclk), .load_on(load_on), .load_cur(load_cur),
    .hv_pin_drv_on(drv_on), .hv_pin_current(cur));

  // clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare and bus tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= wsel;
    adr <= {idx, 2'h0};
    wdat <= {24'h000000, d};
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    rhi = rdat[31:8];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(r, exp);
    chk({7'h00, |rhi}, 8'h00);
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    resetn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'hf;
    wdat = '0;
    load_on = '0;
    load_cur = '0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].idx, rows[i].wd);
      if (!rows[i].we) chk(r, rows[i].exp);
    end
    // a write without its low byte lane is ignored
    wsel = 4'he;
    wb(1'b1, 8'h39, 8'hff);
    wsel = 4'hf;
    rd_chk(8'h39, 8'ha5);
    // events from the reset refresh, masked
    rd_chk(8'h60, 8'hff);
    chk({7'h00, irq}, 8'h00);
    // every select code, currents at the limits
    for (int s = 0; s < 4; s++) begin
      sc = SC_LIMIT[s];
      ol = OL_LIMIT[s];
      foreach (sel_idx[k]) wb(1'b1, sel_idx[k], {4{s[1:0]}});
      load_on <= 8'hbf;
      load_cur <= {8'h80, 8'h00, ol - 8'h01, sc + 8'h01, ol, ol - 8'h01, sc, sc + 8'h01};
      repeat (3) @(posedge mclk);
      rd_chk(8'h36, 8'h12);
      rd_chk(8'h46, 8'h36);
    end
    // a different select in every field
    foreach (sel_idx[k]) wb(1'b1, sel_idx[k], 8'h1b);
    load_on <= 8'hff;
    load_cur <= {8{8'hd1}};
    repeat (3) @(posedge mclk);
    rd_chk(8'h36, 8'ha0);
    rd_chk(8'h46, 8'ha0);
    load_cur <= {8{8'h0c}};
    repeat (3) @(posedge mclk);
    rd_chk(8'h36, 8'h05);
    rd_chk(8'h46, 8'h05);
    // sticky event, mask and clear
    wb(1'b1, 8'h61, 8'h10);
    wb(1'b1, 8'h60, 8'hff);
    rd_chk(8'h60, 8'h00);
    chk({7'h00, irq}, 8'h00);
    load_on <= 8'hef;
    repeat (4) @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    rd_chk(8'h60, 8'h10);
    wb(1'b1, 8'h61, 8'h00);
    repeat (2) @(posedge mclk);
    chk({7'h00, irq}, 8'h00);
    wb(1'b1, 8'h60, 8'h10);
    rd_chk(8'h60, 8'h00);
    // reset in mid-run with the interrupt up
    wb(1'b1, 8'h61, 8'hff);
    load_on <= 8'h00;
    repeat (4) @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({6'h00, ack, irq}, 8'h00);
    resetn <= 1'b1;
    rd_chk(8'h39, 8'h00);
    rd_chk(8'h61, 8'h00);
    complete_run();
  end

  // watchdog
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule
